// file: core/csfr_pkg.sv
package csfr_pkg;
  // ==========================================================================
  // Bus geometry.
  localparam int ADR_W = 8;
  localparam int IDX_W = 6;
  localparam int CHAN_W = 8;
  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_M3_LO = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_M3_HI = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_M4_LO = 6'h1e;
  localparam logic [IDX_W-1:0] IDX_M4_HI = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_VER0 = 6'h20;
  localparam logic [IDX_W-1:0] IDX_VER1 = 6'h21;
  localparam logic [IDX_W-1:0] IDX_VER2 = 6'h22;
  localparam logic [IDX_W-1:0] IDX_VER3 = 6'h23;
  localparam logic [IDX_W-1:0] IDX_BATT = 6'h28;
  localparam logic [IDX_W-1:0] IDX_TEMP = 6'h29;
  localparam logic [IDX_W-1:0] IDX_RIO = 6'h2a;
  localparam logic [IDX_W-1:0] IDX_PARAM = 6'h30;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h31;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h32;
  localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h33;
  // ==========================================================================
  // Field positions and fixed values.
  localparam int PRM_CU_OFF = 7;
  localparam int PRM_CT_OFF = 6;
  localparam int TMP_CU = 0;
  localparam int TMP_CT = 1;
  localparam int BAT_BIT = 0;
  localparam logic [7:0] VER_FILL = 8'hff;
  localparam logic [7:0] VER_NO_CH3 = 8'h00;
  localparam logic [15:0] PARAM_RST = 16'h0000;
  // Interrupt event bits.
  localparam int EV_W = 4;
  localparam int EV_BATT = 0;
  localparam int EV_HEAT = 1;
  localparam int EV_RIO = 2;
  localparam int EV_REFUSE = 3;
  // Battery is sampled this many cycles after reset, once the synchroniser is full.
  localparam logic [1:0] BAT_SAMPLE_CYC = 2'h3;
endpackage : csfr_pkg

// file: core/csfr_sync.sv
`timescale 1ns/100ps
module csfr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : csfr_sync

// file: core/csfr_top.sv
`timescale 1ns/100ps
module csfr_top #(
  parameter logic [15:0] VER_FUNC = 16'h0001,
  parameter logic [15:0] VER_SERIAL = 16'h0002,
  parameter logic [7:0] VER_CH1 = 8'h41,
  parameter logic [7:0] VER_CH2 = 8'h42,
  parameter logic [7:0] VER_CH3 = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [csfr_pkg::ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic battery_low,
  input wire logic cu_overheat,
  input wire logic ct_overheat,
  input wire logic rio_stop,
  input wire logic [csfr_pkg::CHAN_W-1:0] rio_stop_chan,
  input wire logic start_req,
  input wire logic hard_stop_evt,
  output logic [31:0] macro_var3,
  output logic [31:0] macro_var4,
  output logic battery_alarm_input,
  output logic overheat_warning_flag,
  output logic thermal_alarm,
  output logic remote_io_stop_flag,
  output logic start_grant,
  output logic start_refused,
  output logic irq
);
  import csfr_pkg::*;

  // ==========================================================================
  // Pin synchronisers.
  logic bat_s;
  logic cu_s;
  logic ct_s;
  logic rio_s;
  logic [CHAN_W-1:0] chan_s;

  csfr_sync #(.W(CHAN_W + 4)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({rio_stop_chan, rio_stop, ct_overheat, cu_overheat, battery_low}),
    .dout({chan_s, rio_s, ct_s, cu_s, bat_s})
  );

  // ==========================================================================
  // Wishbone decode.
  logic [IDX_W-1:0] idx;
  logic req;
  logic wr;
  logic rd;
  logic ack_d;
  assign idx = wb_adr[ADR_W-1:2];
  assign req = wb_cyc & wb_stb & ~wb_ack;
  assign wr = req & wb_we;
  assign rd = req & ~wb_we;
  assign ack_d = req;

  logic wr_m3l;
  logic wr_m3h;
  logic wr_m4l;
  logic wr_m4h;
  logic wr_prm;
  logic wr_ist;
  logic wr_imk;
  assign wr_m3l = wr & (idx == IDX_M3_LO);
  assign wr_m3h = wr & (idx == IDX_M3_HI);
  assign wr_m4l = wr & (idx == IDX_M4_LO);
  assign wr_m4h = wr & (idx == IDX_M4_HI);
  assign wr_prm = wr & (idx == IDX_PARAM);
  assign wr_ist = wr & (idx == IDX_IRQ_STAT);
  assign wr_imk = wr & (idx == IDX_IRQ_MASK);

  // ==========================================================================
  // Macro input words, byte-lane writable.
  logic [15:0] m3l_q;
  logic [15:0] m3h_q;
  logic [15:0] m4l_q;
  logic [15:0] m4h_q;
  logic [15:0] prm_q;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m3l_q <= 16'h0000;
      m3h_q <= 16'h0000;
      m4l_q <= 16'h0000;
      m4h_q <= 16'h0000;
      prm_q <= PARAM_RST;
    end else begin
      if (wr_m3l) m3l_q <= merge(m3l_q, wb_dat_w, wb_sel);
      if (wr_m3h) m3h_q <= merge(m3h_q, wb_dat_w, wb_sel);
      if (wr_m4l) m4l_q <= merge(m4l_q, wb_dat_w, wb_sel);
      if (wr_m4h) m4h_q <= merge(m4h_q, wb_dat_w, wb_sel);
      if (wr_prm) prm_q <= merge(prm_q, wb_dat_w, wb_sel);
    end
  end

  // The 32-bit view lags the word write by one cycle, like a scan-end transfer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      macro_var3 <= 32'h0000_0000;
      macro_var4 <= 32'h0000_0000;
    end else begin
      macro_var3 <= {m3h_q, m3l_q};
      macro_var4 <= {m4h_q, m4l_q};
    end
  end

  // ==========================================================================
  // Battery alarm: checked once after power-up only.
  // A sag later in the run does not set the cause; only recovery clears it.
  logic [1:0] bat_cnt_q;
  logic bat_sample;
  logic bat_q;
  assign bat_sample = (bat_cnt_q == BAT_SAMPLE_CYC - 2'h1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bat_cnt_q <= 2'h0;
      bat_q <= 1'b0;
    end else begin
      if (bat_cnt_q != BAT_SAMPLE_CYC) bat_cnt_q <= bat_cnt_q + 2'h1;
      if (bat_sample && bat_s) bat_q <= 1'b1;
      else if (!bat_s) bat_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Overheat detection and cause word.
  logic cu_det;
  logic ct_det;
  logic any_det;
  logic [1:0] tmp_q;
  logic [1:0] tmp_d;
  assign cu_det = cu_s & ~prm_q[PRM_CU_OFF];
  assign ct_det = ct_s & ~prm_q[PRM_CT_OFF];
  assign any_det = cu_det | ct_det;
  // A source that cools early keeps its bit until the other cools too.
  assign tmp_d = any_det ? (tmp_q | {ct_det, cu_det}) : 2'b00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmp_q <= 2'b00;
    end else begin
      tmp_q <= tmp_d;
    end
  end

  // ==========================================================================
  // Remote I/O stop channel.
  logic [CHAN_W-1:0] chan_q;
  logic rio_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_q <= '0;
      rio_q <= 1'b0;
    end else begin
      rio_q <= rio_s;
      if (rio_s) chan_q <= chan_s;
    end
  end

  // ==========================================================================
  // Cycle start gate; running operation is never aborted here.
  logic hard_q;
  logic refuse;
  assign refuse = start_req & tmp_q[TMP_CU] & hard_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hard_q <= 1'b1;
      start_grant <= 1'b0;
      start_refused <= 1'b0;
    end else begin
      start_grant <= start_req & ~refuse;
      start_refused <= refuse;
      if (hard_stop_evt) hard_q <= 1'b1;
      else if (start_req && !refuse) hard_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Status outputs and interrupts.
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] ist_q;
  logic [EV_W-1:0] imk_q;
  logic [EV_W-1:0] ist_d;
  assign ev[EV_BATT] = bat_s & bat_sample;
  assign ev[EV_HEAT] = any_det & ~(|tmp_q);
  assign ev[EV_RIO] = rio_s & ~rio_q;
  assign ev[EV_REFUSE] = refuse;
  // A new event beats a write-one-to-clear in the same cycle.
  assign ist_d = (ist_q & ~(wr_ist ? wb_dat_w[EV_W-1:0] : {EV_W{1'b0}})) | ev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_q <= '0;
      imk_q <= '0;
      irq <= 1'b0;
      battery_alarm_input <= 1'b0;
      overheat_warning_flag <= 1'b0;
      thermal_alarm <= 1'b0;
      remote_io_stop_flag <= 1'b0;
    end else begin
      ist_q <= ist_d;
      if (wr_imk) imk_q <= wb_dat_w[EV_W-1:0];
      irq <= |(ist_d & imk_q);
      battery_alarm_input <= bat_q;
      overheat_warning_flag <= |tmp_d;
      thermal_alarm <= |tmp_d;
      remote_io_stop_flag <= rio_s;
    end
  end

  // ==========================================================================
  // Read mux; unmapped indices read zero and still acknowledge.
  logic [15:0] ver0;
  logic [15:0] rmux;
  assign ver0 = {VER_CH3, VER_FILL};

  always_comb begin
    unique case (idx)
      IDX_M3_LO: rmux = m3l_q;
      IDX_M3_HI: rmux = m3h_q;
      IDX_M4_LO: rmux = m4l_q;
      IDX_M4_HI: rmux = m4h_q;
      IDX_VER0: rmux = ver0;
      IDX_VER1: rmux = {VER_CH1, VER_CH2};
      IDX_VER2: rmux = VER_SERIAL;
      IDX_VER3: rmux = VER_FUNC;
      IDX_BATT: rmux = {15'h0000, bat_q};
      IDX_TEMP: rmux = {14'h0000, tmp_q};
      IDX_RIO: rmux = {{(16 - CHAN_W){1'b0}}, chan_q};
      IDX_PARAM: rmux = prm_q;
      IDX_IRQ_STAT: rmux = {{(16 - EV_W){1'b0}}, ist_q};
      IDX_IRQ_MASK: rmux = {{(16 - EV_W){1'b0}}, imk_q};
      IDX_FLAGS: rmux = {12'h000, thermal_alarm, remote_io_stop_flag, overheat_warning_flag, battery_alarm_input};
      default: rmux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end else begin
      wb_ack <= ack_d;
      if (rd) wb_dat_r <= {16'h0000, rmux};
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_m3l;
    wr_m3l && (wb_sel[1:0] == 2'b11);
  endsequence
  sequence s_seen_m3;
    ##2 macro_var3[15:0] == $past(wb_dat_w[15:0], 2);
  endsequence
  a_macro_pair3: assert property (s_wr_m3l |-> s_seen_m3)
    else $error("Pair three low word not visible.");
  a_macro_high: assert property (wr_m4h && wb_sel[1:0] == 2'b11 |-> ##2 macro_var4[31:16] == $past(wb_dat_w[15:0], 2))
    else $error("Pair four high half wrong.");
  a_ver_fill: assert property (rd && idx == IDX_VER0 |=> wb_ack && wb_dat_r[15:0] == {VER_CH3, 8'hff})
    else $error("Version fill byte wrong.");
  a_ver_chars: assert property (rd && idx == IDX_VER1 |=> wb_dat_r[15:8] == VER_CH1 && wb_dat_r[7:0] == VER_CH2)
    else $error("Version characters misplaced.");
  a_bat_hold: assert property (bat_q && bat_s |=> bat_q)
    else $error("Battery cause dropped early.");
  a_bat_set: assert property (bat_sample && bat_s |=> ##1 battery_alarm_input)
    else $error("Battery alarm not raised.");
  a_heat_set: assert property (cu_det |=> tmp_q[TMP_CU] && overheat_warning_flag)
    else $error("Unit overheat not flagged.");
  a_heat_keep: assert property (tmp_q[TMP_CU] && !cu_det && ct_det |=> tmp_q[TMP_CU])
    else $error("Cause cleared while terminal hot.");
  a_heat_clear: assert property (!any_det |=> tmp_q == 2'b00 && !overheat_warning_flag)
    else $error("Flag left on with no overheat.");
  a_gate_cu: assert property (prm_q[PRM_CU_OFF] && !tmp_q[TMP_CU] |=> !tmp_q[TMP_CU])
    else $error("Disabled source detected.");
  a_start_refuse: assert property (start_req && tmp_q[TMP_CU] && hard_q |=> start_refused && !start_grant)
    else $error("Start not refused.");
  a_start_ct: assert property (start_req && !tmp_q[TMP_CU] |=> start_grant)
    else $error("Start refused without unit alarm.");
  a_rio_chan: assert property (rio_s |=> chan_q == $past(chan_s) && remote_io_stop_flag)
    else $error("Stop channel not captured.");
  a_ro_temp: assert property (wr && idx == IDX_TEMP && any_det == $past(any_det) |=> $stable(tmp_q) || any_det)
    else $error("Cause word changed by write.");

  sequence s_bus_req;
    req;
  endsequence
  // A request is answered in the very next cycle, and the answer never repeats back to back.
  a_ack_answer: assert property (s_bus_req |=> wb_ack)
    else $error("Request not acknowledged.");
  a_ack_pulse: assert property (wb_ack |=> !wb_ack)
    else $error("Acknowledge held too long.");
  // Macro words change only by a write to their own index.
  a_m3_hold: assert property (!wr_m3l |=> $stable(m3l_q))
    else $error("Macro word changed without a write.");
  a_ct_bit: assert property (ct_det |=> tmp_q[TMP_CT])
    else $error("Terminal overheat not flagged.");
  a_ct_keep: assert property (tmp_q[TMP_CT] && !ct_det && cu_det |=> tmp_q[TMP_CT])
    else $error("Terminal cause cleared while unit hot.");
  a_hard_set: assert property (hard_stop_evt |=> hard_q)
    else $error("Stop state not recorded.");
  a_refuse_ev: assert property (refuse |=> ist_q[EV_REFUSE] && start_refused)
    else $error("Refused start not reported.");
  a_rio_hold: assert property (!rio_s |=> chan_q == $past(chan_q))
    else $error("Stop channel changed without a stop.");
  a_bat_event: assert property (bat_sample && bat_s |=> ist_q[EV_BATT])
    else $error("Battery event not latched.");
endmodule : csfr_top

// file: sim/csfr_pin_model.sv
`timescale 1ns/100ps
// ====================
// Sensor and remote I/O side of the register file.
module csfr_pin_model (
  input wire logic clk,
  input wire logic batt_lvl,
  input wire logic cu_lvl,
  input wire logic ct_lvl,
  input wire logic stop_lvl,
  input wire logic [csfr_pkg::CHAN_W-1:0] chan_val,
  output logic battery_low,
  output logic cu_overheat,
  output logic ct_overheat,
  output logic rio_stop,
  output logic [csfr_pkg::CHAN_W-1:0] rio_stop_chan
);
  initial begin
    {battery_low, cu_overheat, ct_overheat, rio_stop} = 4'h0;
    rio_stop_chan = '0;
  end
  // The channel bus is held only while the stop is shown; otherwise it toggles so a stale value is never trusted.
  always @(posedge clk) begin
    battery_low <= batt_lvl;
    cu_overheat <= cu_lvl;
    ct_overheat <= ct_lvl;
    rio_stop <= stop_lvl;
    rio_stop_chan <= stop_lvl ? chan_val : ~rio_stop_chan;
  end
endmodule : csfr_pin_model

// file: sim/tb_controller_status_file_registers.sv
`timescale 1ns/100ps
module tb_controller_status_file_registers;
  import csfr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [ADR_W-1:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic battery_low, cu_overheat, ct_overheat, rio_stop, start_req, hard_stop_evt;
  logic [CHAN_W-1:0] rio_stop_chan, chan_val;
  logic batt_lvl, cu_lvl, ct_lvl, stop_lvl;
  logic [31:0] macro_var3, macro_var4;
  logic battery_alarm_input, overheat_warning_flag, thermal_alarm, remote_io_stop_flag;
  logic start_grant, start_refused, irq;
  logic [15:0] mv [4];
  int mismatches = 0;
  int num_checks = 0;

  always #25 clk = ~clk;

  csfr_top csfr_top_inst (.clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r,
    .wb_ack, .battery_low, .cu_overheat, .ct_overheat, .rio_stop, .rio_stop_chan, .start_req, .hard_stop_evt,
    .macro_var3, .macro_var4, .battery_alarm_input, .overheat_warning_flag, .thermal_alarm,
    .remote_io_stop_flag, .start_grant, .start_refused, .irq);
  csfr_pin_model csfr_pin_model_inst (.clk, .batt_lvl, .cu_lvl, .ct_lvl, .stop_lvl, .chan_val,
    .battery_low, .cu_overheat, .ct_overheat, .rio_stop, .rio_stop_chan);

  // ====================
  // Tasks.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Entered just after a rising edge; leaves one idle cycle behind.
  task automatic wb(input logic [7:0] a, input logic we, input logic [15:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'h3;
    wb_dat_w <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      stop_test;
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] exp);
    wb(a, 1'b0, 16'h0000);
    chk(nm, {16'h0000, exp}, rd);
  endtask : rc

  task automatic start_chk(input logic g, input logic r);
    logic sg, sr;
    sg = 1'b0;
    sr = 1'b0;
    start_req <= 1'b1;
    @(posedge clk);
    start_req <= 1'b0;
    repeat (3) begin
      @(posedge clk);
      sg |= start_grant;
      sr |= start_refused;
    end
    chk("start_grant", g, sg);
    chk("start_refused", r, sr);
  endtask : start_chk

  // ====================
  // Main sequence.
  initial begin
    {wb_cyc, wb_stb, wb_we, start_req, hard_stop_evt} = 5'h00;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0;
    {batt_lvl, cu_lvl, ct_lvl, stop_lvl} = 4'h8;
    chan_val = 8'h00;
    mv = '{16'h1234, 16'hfedc, 16'h8001, 16'h7ffe};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("battery_alarm_input", 1, battery_alarm_input);
    rc("battery_cause", 8'ha0, 16'h0001);
    rc("param", 8'hc0, 16'h0000);
    rc("irq_status", 8'hc4, 16'h0001);
    chk("irq", 0, irq);
    wb(8'hc8, 1'b1, 16'h0001);
    chk("irq", 1, irq);
    wb(8'hc4, 1'b1, 16'h0001);
    rc("irq_status", 8'hc4, 16'h0000);
    chk("irq", 0, irq);
    wb(8'ha0, 1'b1, 16'h0000);
    rc("battery_cause", 8'ha0, 16'h0001);
    repeat (10) @(posedge clk);
    rc("battery_cause", 8'ha0, 16'h0001);
    batt_lvl <= 1'b0;
    repeat (6) @(posedge clk);
    rc("battery_cause", 8'ha0, 16'h0000);
    chk("battery_alarm_input", 0, battery_alarm_input);
    $display("battery test done");
    rc("version0", 8'h80, {VER_NO_CH3, VER_FILL});
    rc("version1", 8'h84, 16'h4142);
    rc("version2", 8'h88, 16'h0002);
    rc("version3", 8'h8c, 16'h0001);
    wb(8'h80, 1'b1, 16'h1234);
    rc("version0", 8'h80, 16'h00ff);
    rc("unmapped", 8'hfc, 16'h0000);
    $display("version test done");
    for (int i = 0; i < 4; i++) wb(8'h70 + 8'(4 * i), 1'b1, mv[i]);
    chk("macro_var3", {mv[1], mv[0]}, macro_var3);
    chk("macro_var4", {mv[3], mv[2]}, macro_var4);
    for (int i = 0; i < 4; i++) rc("macro_word", 8'h70 + 8'(4 * i), mv[i]);
    $display("macro test done");
    cu_lvl <= 1'b1;
    repeat (5) @(posedge clk);
    rc("temp_cause", 8'ha4, 16'h0001);
    chk("overheat_warning_flag", 1, overheat_warning_flag);
    chk("thermal_alarm", 1, thermal_alarm);
    rc("flags", 8'hcc, 16'h000a);
    ct_lvl <= 1'b1;
    repeat (5) @(posedge clk);
    rc("temp_cause", 8'ha4, 16'h0003);
    cu_lvl <= 1'b0;
    repeat (5) @(posedge clk);
    rc("temp_cause", 8'ha4, 16'h0003);
    chk("thermal_alarm", 1, thermal_alarm);
    ct_lvl <= 1'b0;
    repeat (5) @(posedge clk);
    rc("temp_cause", 8'ha4, 16'h0000);
    chk("overheat_warning_flag", 0, overheat_warning_flag);
    chk("thermal_alarm", 0, thermal_alarm);
    wb(8'ha4, 1'b1, 16'h0003);
    rc("temp_cause", 8'ha4, 16'h0000);
    ct_lvl <= 1'b1;
    repeat (5) @(posedge clk);
    start_chk(1'b1, 1'b0);
    ct_lvl <= 1'b0;
    cu_lvl <= 1'b1;
    repeat (5) @(posedge clk);
    start_chk(1'b1, 1'b0);
    hard_stop_evt <= 1'b1;
    @(posedge clk);
    hard_stop_evt <= 1'b0;
    @(posedge clk);
    start_chk(1'b0, 1'b1);
    rc("irq_status", 8'hc4, 16'h000a);
    chk("irq", 0, irq);
    cu_lvl <= 1'b0;
    repeat (5) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      wb(8'hc0, 1'b1, (k == 0) ? 16'h0080 : 16'h0040);
      cu_lvl <= (k == 0);
      ct_lvl <= (k == 1);
      repeat (5) @(posedge clk);
      rc("temp_cause", 8'ha4, 16'h0000);
      chk("overheat_warning_flag", 0, overheat_warning_flag);
      cu_lvl <= 1'b0;
      ct_lvl <= 1'b0;
      repeat (5) @(posedge clk);
    end
    wb(8'hc0, 1'b1, 16'h0000);
    $display("overheat test done");
    chan_val <= 8'h5a;
    stop_lvl <= 1'b1;
    repeat (5) @(posedge clk);
    rc("stop_channel", 8'ha8, 16'h005a);
    chk("remote_io_stop_flag", 1, remote_io_stop_flag);
    stop_lvl <= 1'b0;
    repeat (5) @(posedge clk);
    rc("stop_channel", 8'ha8, 16'h005a);
    chk("remote_io_stop_flag", 0, remote_io_stop_flag);
    rc("irq_status", 8'hc4, 16'h000e);
    $display("remote io test done");
    stop_test;
  end
endmodule : tb_controller_status_file_registers
